// File: verilog/mah_pkg.sv
// mah_pkg: shared constants and types for the ack/nack handler.
// assumes one 20 MHz clock and a synchronous active-high reset.
package mah_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // extended interframe space, figure in microseconds (plain default)
   localparam int EIFS_US = 100;
   localparam int EIFS_CYC = (EIFS_US * 1000 + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
   // longest wait for a response, microseconds (plain default)
   localparam int RSP_WAIT_US = 200;
   localparam int RSP_WAIT_CYC = (RSP_WAIT_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   // fcs byte positions in the echoed header
   localparam int FCS_HI_MSB = 15;
   localparam int FCS_HI_LSB = 8;
   localparam int FCS_LO_MSB = 7;
   localparam int FCS_LO_LSB = 0;
   localparam logic [15:0] FCS_RST = 16'h0000;
   // transmit-side states
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_EIFS = 2'b10
   } mah_tx_state_type;
endpackage

// File: verilog/mah_ack_nack_handler.sv
// mah_ack_nack_handler: decides ack/nack replies for received frames and
// checks replies to our own acknowledged transmissions.
// assumes the phy/mac around it gives one-cycle strobes with stable data.
//
// Overview of operation
// - replies go out only as frame control headers
// - good fcs, requested, addressed to us: ack
// - bad fcs, requested, addressed to us: nack
// - collision-caused error: stay silent, no nack
// - no response: collision, retry after eifs
// - valid nack: retry with csma random backoff
// - echo fcs: high byte tone map, low phase
// - echoed fcs mismatch: ignore, treat as collision
`timescale 1ns/100ps
`default_nettype none
module mah_ack_nack_handler
   import mah_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   // receive side: one frame end strobe with its decoded header fields
   input wire logic RX_FRAME_DONE_I,
   input wire logic RX_FCS_OK_I,
   input wire logic RX_ACK_REQ_I,
   input wire logic RX_COLLISION_I,
   input wire logic [15:0] RX_DST_ADDR_I,
   input wire logic [15:0] RX_DST_PAN_I,
   input wire logic [15:0] RX_FCS_I,
   input wire logic [15:0] OWN_ADDR_I,
   input wire logic [15:0] OWN_PAN_I,
   // reply header request towards the phy
   output logic RSP_SEND_O,
   output logic RSP_IS_NACK_O,
   output logic [7:0] TONE_MAP_BYTE_O,
   output logic [7:0] PHASE_DETECTION_COUNTER_BYTE_O,
   // transmit side
   input wire logic TX_DONE_I,
   input wire logic TX_ACK_REQ_I,
   input wire logic [15:0] TX_FCS_I,
   input wire logic RSP_RCVD_I,
   input wire logic RSP_NACK_I,
   input wire logic [7:0] RSP_TONE_MAP_BYTE_I,
   input wire logic [7:0] RSP_PHASE_DETECTION_COUNTER_BYTE_I,
   output logic TX_SUCCESS_O,
   output logic RETRY_EIFS_O,
   output logic RETRY_CSMA_O,
   output logic TX_BUSY_O
);
   // timing of the receive group:
   //   edge 0: frame end strobe sampled together with its header fields
   //   edge 1: reply strobe high for one cycle, with kind and echo bytes
   //   the kind flag and both echo bytes hold until the next reply, so a
   //   slow header builder may read them after the strobe has dropped
   // back to back frame ends are fine: each edge is decided on its own,
   // and nothing is queued, so the phy must take every strobe it gets
   //
   // timing of the transmit group:
   //   edge 0: frame sent strobe with ack request and its check sequence
   //   edge 1: busy goes high, the wait counter is loaded
   //   edge k: reply strobe sampled while waiting, echo compared and found matching
   //   edge k+1: exactly one outcome pulse, busy low again
   // silence for the whole wait window and a wrong echo both end in the
   // extended space, after which the eifs retry pulse is given
   //
   // hazards and limits:
   //   a sent strobe while busy is dropped; the mac above must wait for
   //   busy to fall before handing over the next acknowledged frame
   //   replies that arrive while idle or during the extended space are
   //   dropped, since no frame of ours could be answered by them
   //   the collision flag is trusted as given; a phy that cannot tell a
   //   collision from noise should hold it low and let nacks go out
   //   the reply carries no timing of its own: the phy decides when the
   //   header goes on the line after the reply strobe
   //
   // trade-offs:
   //   one shared down counter serves both the response wait and the
   //   extended space, as the two never overlap
   //   the counter is 16 bits wide, ample for both default spans at this
   //   clock; longer spans need a wider counter, not a prescaler
   //   outcome pulses are registered so the mac above sees clean strobes
   //   one cycle after the deciding edge, never a decode glitch
   // receive decision
   logic rx_match;
   logic rx_ack;
   logic rx_nack;
   logic rsp_send_r;
   logic rsp_nack_r;
   logic [7:0] tm_r;
   logic [7:0] pdc_r;

   // addressed to us and reply wanted
   assign rx_match = RX_FRAME_DONE_I && RX_ACK_REQ_I
                     && (RX_DST_ADDR_I == OWN_ADDR_I)
                     && (RX_DST_PAN_I == OWN_PAN_I);
   assign rx_ack = rx_match && RX_FCS_OK_I;
   // a collision-induced error gets no reply, so the sender backs off
   assign rx_nack = rx_match && !RX_FCS_OK_I && !RX_COLLISION_I;

   // reply is a header-only request with the fcs echoed in it
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rsp_send_r <= 1'b0;
         rsp_nack_r <= 1'b0;
         tm_r <= 8'h00;
         pdc_r <= 8'h00;
      end else begin
         rsp_send_r <= rx_ack || rx_nack;
         if (rx_ack || rx_nack) begin
            rsp_nack_r <= rx_nack;
            tm_r <= RX_FCS_I[FCS_HI_MSB:FCS_HI_LSB];
            pdc_r <= RX_FCS_I[FCS_LO_MSB:FCS_LO_LSB];
         end
      end
   end

   assign RSP_SEND_O = rsp_send_r;
   assign RSP_IS_NACK_O = rsp_nack_r;
   assign TONE_MAP_BYTE_O = tm_r;
   assign PHASE_DETECTION_COUNTER_BYTE_O = pdc_r;

   // transmit side: wait for a matching reply
   mah_tx_state_type state_r, state_nxt;
   logic [15:0] sent_fcs_r;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [15:0] echo_fcs;
   logic rsp_valid;
   logic rsp_bad;
   logic wait_over;
   logic tx_start;
   logic succ_r, succ_nxt;
   logic eifs_r, eifs_nxt;
   logic csma_r, csma_nxt;

   assign echo_fcs = {RSP_TONE_MAP_BYTE_I,
                      RSP_PHASE_DETECTION_COUNTER_BYTE_I};
   // replies outside the wait state are dropped here
   assign rsp_valid = (state_r == TX_WAIT) && RSP_RCVD_I
                      && (echo_fcs == sent_fcs_r);
   assign rsp_bad = (state_r == TX_WAIT) && RSP_RCVD_I
                    && (echo_fcs != sent_fcs_r);
   assign wait_over = (cnt_r == CNT_ONE);
   // only an idle handler takes a new acknowledged frame
   assign tx_start = (state_r == TX_IDLE) && TX_DONE_I && TX_ACK_REQ_I;

   // next state; a wrong echo counts as a collision, like silence
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      succ_nxt = 1'b0;
      eifs_nxt = 1'b0;
      csma_nxt = 1'b0;
      case (state_r)
         TX_IDLE: begin
            if (TX_DONE_I && TX_ACK_REQ_I) begin
               state_nxt = TX_WAIT;
               cnt_nxt = CNT_W'(RSP_WAIT_CYC);
            end
         end
         TX_WAIT: begin
            if (rsp_valid && !RSP_NACK_I) begin
               succ_nxt = 1'b1;
               state_nxt = TX_IDLE;
            end else if (rsp_valid) begin
               csma_nxt = 1'b1;
               state_nxt = TX_IDLE;
            end else if (rsp_bad || wait_over) begin
               state_nxt = TX_EIFS;
               cnt_nxt = CNT_W'(EIFS_CYC);
            end else begin
               cnt_nxt = cnt_r - CNT_ONE;
            end
         end
         TX_EIFS: begin
            if (wait_over) begin
               eifs_nxt = 1'b1;
               state_nxt = TX_IDLE;
               cnt_nxt = CNT_ZERO;
            end else begin
               cnt_nxt = cnt_r - CNT_ONE;
            end
         end
         default: begin
            state_nxt = TX_IDLE;
            cnt_nxt = CNT_ZERO;
         end
      endcase
   end

   // state and one-cycle outcome pulses
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         state_r <= TX_IDLE;
         cnt_r <= CNT_ZERO;
         succ_r <= 1'b0;
         eifs_r <= 1'b0;
         csma_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         succ_r <= succ_nxt;
         eifs_r <= eifs_nxt;
         csma_r <= csma_nxt;
      end
   end

   // remember what we sent so the echo can be checked
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         sent_fcs_r <= FCS_RST;
      end else if (tx_start) begin
         sent_fcs_r <= TX_FCS_I;
      end
   end

   assign TX_SUCCESS_O = succ_r;
   assign RETRY_EIFS_O = eifs_r;
   assign RETRY_CSMA_O = csma_r;
   assign TX_BUSY_O = (state_r != TX_IDLE);
endmodule
`default_nettype wire

// File: bench/mah_monitor.sv
// mah_monitor: port checks for the ack/nack handler.
// assumes a bind onto the handler top module.
`timescale 1ns/100ps
`default_nettype none
module mah_monitor (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic RX_FRAME_DONE_I,
   input wire logic RX_FCS_OK_I,
   input wire logic RX_ACK_REQ_I,
   input wire logic RX_COLLISION_I,
   input wire logic RSP_SEND_O,
   input wire logic RSP_IS_NACK_O,
   input wire logic TX_DONE_I,
   input wire logic TX_ACK_REQ_I,
   input wire logic RSP_RCVD_I,
   input wire logic RSP_NACK_I,
   input wire logic TX_SUCCESS_O,
   input wire logic RETRY_CSMA_O,
   input wire logic TX_BUSY_O,
   input wire logic [15:0] RX_DST_ADDR_I,
   input wire logic [15:0] RX_DST_PAN_I,
   input wire logic [15:0] RX_FCS_I,
   input wire logic [15:0] OWN_ADDR_I,
   input wire logic [15:0] OWN_PAN_I,
   input wire logic [15:0] TX_FCS_I,
   input wire logic [7:0] TONE_MAP_BYTE_O,
   input wire logic [7:0] PHASE_DETECTION_COUNTER_BYTE_O,
   input wire logic [7:0] RSP_TONE_MAP_BYTE_I,
   input wire logic [7:0] RSP_PHASE_DETECTION_COUNTER_BYTE_I
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   // strobe that asked for a reply and is addressed to us
   wire m = RX_FRAME_DONE_I && RX_ACK_REQ_I && RX_DST_ADDR_I == OWN_ADDR_I
      && RX_DST_PAN_I == OWN_PAN_I;
   // sent fcs is held by the bench, so no private copy is kept
   wire e = {RSP_TONE_MAP_BYTE_I, RSP_PHASE_DETECTION_COUNTER_BYTE_I}
      == TX_FCS_I;
   sequence s_sent; TX_DONE_I && TX_ACK_REQ_I && !TX_BUSY_O; endsequence
   sequence s_rsp; TX_BUSY_O && RSP_RCVD_I && e; endsequence
   property p_ack; m && RX_FCS_OK_I |=> RSP_SEND_O && !RSP_IS_NACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_nack; m && !RX_FCS_OK_I && !RX_COLLISION_I |=> RSP_SEND_O
      && RSP_IS_NACK_O; endproperty
   a_nack: assert property (p_nack) else $error("no nack");
   property p_quiet; !m || !RX_FCS_OK_I && RX_COLLISION_I |=> !RSP_SEND_O;
   endproperty
   a_quiet: assert property (p_quiet) else $error("stray reply");
   property p_echo; RSP_SEND_O |-> {TONE_MAP_BYTE_O,
      PHASE_DETECTION_COUNTER_BYTE_O} == $past(RX_FCS_I); endproperty
   a_echo: assert property (p_echo) else $error("bad echo");
   property p_busy; s_sent |=> TX_BUSY_O; endproperty
   a_busy: assert property (p_busy) else $error("not waiting");
   property p_ok; s_rsp ##0 !RSP_NACK_I |=> TX_SUCCESS_O && !TX_BUSY_O;
   endproperty
   a_ok: assert property (p_ok) else $error("ack lost");
   property p_csma; s_rsp ##0 RSP_NACK_I |=> RETRY_CSMA_O; endproperty
   a_csma: assert property (p_csma) else $error("no csma retry");
   property p_bad; RSP_RCVD_I && !e |=> !TX_SUCCESS_O && !RETRY_CSMA_O;
   endproperty
   a_bad: assert property (p_bad) else $error("bad echo taken");
   property p_idle; RSP_RCVD_I && !TX_BUSY_O |=> !TX_SUCCESS_O
      && !RETRY_CSMA_O; endproperty
   a_idle: assert property (p_idle) else $error("idle reply");
endmodule
bind mah_ack_nack_handler mah_monitor u_mon (.*);
`default_nettype wire

// File: bench/mah_peer_model.sv
// mah_peer_model: far station answering with a header reply.
// assumes one go pulse per wanted reply.
`timescale 1ns/100ps
`default_nettype none
module mah_peer_model (
   input wire logic clk_i, go_i, nack_i, bad_i,
   input wire logic [15:0] fcs_i,
   output logic rcvd_o = 1'b0, nack_o = 1'b0,
   output logic [7:0] tm_o = 8'h00, pdc_o = 8'h00
);
   // header-only reply echoing the fcs, high byte first; bad_i corrupts it
   // on purpose, and an idle line toggles, so stale bytes match the fcs only on every other cycle
   always @(posedge clk_i) begin
      rcvd_o <= go_i;
      nack_o <= go_i && nack_i;
      {tm_o, pdc_o} <= go_i ? fcs_i ^ {16{bad_i}} : ~{tm_o, pdc_o};
   end
endmodule
`default_nettype wire

// File: bench/mah_ack_nack_handler_bench.sv
// mah_ack_nack_handler_bench: self-checking bench for the handler.
// assumes the peer model answers one cycle after its go pulse.
`timescale 1ns/100ps
`default_nettype none
module mah_ack_nack_handler_bench;
   import mah_pkg::*;
   localparam logic [15:0] ME = 16'h1234, PAN = 16'hBEEF;
   // row: fcs ok, ack req, collision, addr hit, pan hit, send, nack
   localparam logic [6:0] ROWS [8] = '{7'h6E, 7'h2F, 7'h3C, 7'h4C,
      7'h64, 7'h68, 7'h0C, 7'h24};
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, ok = 1'b0, rq = 1'b0;
   logic col = 1'b0, td = 1'b0, tq = 1'b0, go = 1'b0, nk = 1'b0, bad = 1'b0;
   logic [15:0] ra = 16'h0000, rp = 16'h0000, rf = 16'h0000, tf = 16'h0000;
   logic snd, isn, rcv, rnk, suc, rte, rtc, bsy;
   logic [7:0] tm, pd, rtm, rpd;
   int fails = 0, total_checks = 0, n;
   always #25 clk = ~clk;
   mah_ack_nack_handler dut (.MCLK_I(clk), .SYS_RST_I(rst),
      .RX_FRAME_DONE_I(rd), .RX_FCS_OK_I(ok), .RX_ACK_REQ_I(rq),
      .RX_COLLISION_I(col), .RX_DST_ADDR_I(ra), .RX_DST_PAN_I(rp),
      .RX_FCS_I(rf), .OWN_ADDR_I(ME), .OWN_PAN_I(PAN), .RSP_SEND_O(snd),
      .RSP_IS_NACK_O(isn), .TONE_MAP_BYTE_O(tm),
      .PHASE_DETECTION_COUNTER_BYTE_O(pd), .TX_DONE_I(td),
      .TX_ACK_REQ_I(tq), .TX_FCS_I(tf), .RSP_RCVD_I(rcv), .RSP_NACK_I(rnk),
      .RSP_TONE_MAP_BYTE_I(rtm), .RSP_PHASE_DETECTION_COUNTER_BYTE_I(rpd),
      .TX_SUCCESS_O(suc), .RETRY_EIFS_O(rte), .RETRY_CSMA_O(rtc),
      .TX_BUSY_O(bsy));
   mah_peer_model peer (.clk_i(clk), .go_i(go), .nack_i(nk), .bad_i(bad),
      .fcs_i(tf), .rcvd_o(rcv), .nack_o(rnk), .tm_o(rtm), .pdc_o(rpd));
   task automatic chk(input string s, input logic [15:0] g, e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic print_verdict;
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one acknowledged frame; the fcs stays put until the next one
   task automatic tx(input logic [15:0] f);
      @(posedge clk);
      td <= 1'b1;
      tq <= 1'b1;
      tf <= f;
      @(posedge clk);
      td <= 1'b0;
      #1 chk("busy", bsy, 1'b1);
   endtask
   // peer reply, then settle past the outcome edge
   task automatic reply(input logic r_nk, r_bad);
      @(posedge clk);
      go <= 1'b1;
      nk <= r_nk;
      bad <= r_bad;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_eifs(input int lo, hi);
      n = 0;
      while (rte !== 1'b1 && n < hi) begin
         @(posedge clk);
         #1 n++;
      end
      chk("eifs wait", 16'(rte === 1'b1 && n >= lo && n <= hi), 16'h0001);
   endtask
   // cut a hang short well past the longest expected run
   initial begin
      repeat (12000) @(posedge clk);
      fails++;
      print_verdict;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // rows back to back: each edge loads one row and checks the last
      for (int i = 0; i <= 8; i++) begin
         @(posedge clk);
         rd <= (i < 8);
         {ok, rq, col} <= ROWS[i % 8][6:4];
         ra <= ROWS[i % 8][3] ? ME : ~ME;
         rp <= ROWS[i % 8][2] ? PAN : ~PAN;
         rf <= 16'hA5C0 + 16'(i);
         #1;
         if (i > 0) chk("send", snd, ROWS[i - 1][1]);
         if (i > 0 && ROWS[i - 1][1]) begin
            chk("nack", isn, ROWS[i - 1][0]);
            chk("echo", {tm, pd}, 16'hA5BF + 16'(i));
         end
      end
      reply(1'b0, 1'b0);
      chk("idle reply", {suc, rtc, bsy}, 3'b000);
      tx(16'h1357);
      repeat (7) @(posedge clk);
      reply(1'b0, 1'b0);
      chk("ack", {suc, bsy}, 2'b10);
      tx(16'h2468);
      reply(1'b1, 1'b0);
      chk("nack retry", {rtc, suc, bsy}, 3'b100);
      tx(16'h0F0F);
      reply(1'b0, 1'b1);
      chk("wrong echo", {suc, rtc}, 2'b00);
      wait_eifs(EIFS_CYC - 5, EIFS_CYC + 5);
      tx(16'h7E81);
      wait_eifs(RSP_WAIT_CYC + EIFS_CYC - 8, RSP_WAIT_CYC + EIFS_CYC + 8);
      // a sent frame that wants no ack must not start a wait
      @(posedge clk);
      td <= 1'b1;
      tq <= 1'b0;
      @(posedge clk);
      td <= 1'b0;
      tq <= 1'b1;
      #1 chk("no ack wanted", bsy, 1'b0);
      tx(16'h5A5A);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1 chk("reset", {snd, suc, rte, rtc, bsy}, 5'h00);
      print_verdict;
   end
endmodule
`default_nettype wire
